// ===== tcp_defines.svh
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// ----------------------------------------------------------------
// Mode select codes
// ----------------------------------------------------------------
`define TCP_MODE_TIMER8    3'h0
`define TCP_MODE_PDO8      3'h1
`define TCP_MODE_PWM8      3'h2
`define TCP_MODE_RSVD      3'h3
`define TCP_MODE_TIMER16   3'h4
`define TCP_MODE_WARMUP    3'h5
`define TCP_MODE_PWM16     3'h6
`define TCP_MODE_PPG16     3'h7
`define TCP_MODE_CASC_BIT  2

// ----------------------------------------------------------------
// Clock select codes and prescaler taps
// ----------------------------------------------------------------
`define TCP_CK_SLOWEST     3'h0
`define TCP_CK_DIV7        3'h1
`define TCP_CK_DIV5        3'h2
`define TCP_CK_DIV3        3'h3
`define TCP_CK_LF          3'h4
`define TCP_CK_DIV1        3'h5
`define TCP_CK_HF          3'h6
`define TCP_CK_PIN         3'h7
`define TCP_DIV_WIDTH      11
`define TCP_LF_DIV_WIDTH   3
`define TCP_RESET_COUNT    8'h00

`endif

// ===== tcp_pkg.sv
package tcp_pkg;
  typedef logic [2:0] tcp_mode_t;
  typedef logic [2:0] tcp_ck_t;
  typedef logic [7:0] tcp_byte_t;
endpackage

// ===== tcp_counter8.sv
`timescale 1ns/100ps
`include "tcp_defines.svh"

module tcp_counter8
  import tcp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic            run,
  input  wire logic            tick,
  input  wire logic            cmp_en,
  input  wire tcp_pkg::tcp_byte_t period,
  output tcp_pkg::tcp_byte_t   count,
  output logic                 match,
  output logic                 wrap
);
  import tcp_pkg::*;

  typedef struct packed {
    tcp_byte_t cnt;
  } tcp_c8_s;

  tcp_c8_s st_r;
  tcp_c8_s st_nxt;

  // ----------------------------------------------------------------
  // Count, compare and clear
  // ----------------------------------------------------------------
  // Period read live each tick, no shadow copy
  always_comb begin
    st_nxt = st_r;
    match  = run && tick && cmp_en && (st_r.cnt == period);
    wrap   = run && tick && (st_r.cnt == 8'hFF);
    if (!run) begin
      st_nxt.cnt = `TCP_RESET_COUNT;
    end else if (match) begin
      st_nxt.cnt = `TCP_RESET_COUNT;
    end else if (tick) begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.cnt;
endmodule

// ===== tcp_timer_pair.sv
`timescale 1ns/100ps
`include "tcp_defines.svh"

// Operation
// R1: Software keeps upper mode, clock and flip-flop fixed while running.
// R2: Stopping write keeps fields; starting write may program them.
// R3: Upper mode 1xx clocks upper counter from lower overflow.
// R4: Software sets lower mode 011 for any 16-bit operation.
// R5: 16-bit uses lower clock select, upper run and flip-flop.
// R6: Output suppress high blocks every pulse on timer output.
// R7: Normal/idle: only legal taps per mode reach the counter.
// R8: Slow/sleep: only slowest tap, or low clock for PWM. Code takes only the raw high clock for warm-up in slow state.
// R9: Period 1..255 in 8-bit timer, event, divider modes.
// R10: Width 2..254 in 8-bit PWM, 2..65534 in 16-bit.
// R11: 16-bit timer period 1..65535.
// R12: Warm-up period 256..65535.
// R13: PROGRAMMABLE_PULSE width at least 1 and width plus one below period.
// R14: Lower and upper counters cascade as low and high byte.
// R15: 8-bit timer counts, matches period, interrupts, clears, resumes.
// R16: Software holds flip-flop control zero in timer mode.
// R17: Period not buffered; written value compared at once.
// R18: Slowest tap is high/2^11, or low/2^3 by tap select or slow.
// R19: Match interrupt is a single-cycle pulse on the match edge.
module tcp_timer_pair
  import tcp_pkg::*;
(
  input  wire logic               CORE_CLK,
  input  wire logic               NRST,
  input  wire logic               HIGH_FREQ_CLOCK_EN,
  input  wire logic               LOW_FREQ_CLOCK_EN,
  input  wire logic               SLOW_STATE,
  input  wire logic               PRESCALER_TAP_SELECT,
  input  wire tcp_pkg::tcp_mode_t LOWER_MODE_SELECT,
  input  wire tcp_pkg::tcp_ck_t   LOWER_CLOCK_SELECT,
  input  wire logic               LOWER_RUN_CONTROL,
  input  wire tcp_pkg::tcp_byte_t LOWER_PERIOD,
  input  wire tcp_pkg::tcp_mode_t UPPER_MODE_SELECT,
  input  wire tcp_pkg::tcp_ck_t   UPPER_CLOCK_SELECT,
  input  wire logic               UPPER_RUN_CONTROL,
  input  wire logic               UPPER_FLIPFLOP_INIT,
  input  wire tcp_pkg::tcp_byte_t UPPER_PERIOD,
  input  wire logic               OUTPUT_SUPPRESS,
  output tcp_pkg::tcp_byte_t      LOWER_COUNT,
  output tcp_pkg::tcp_byte_t      UPPER_COUNT,
  output logic                    LOWER_MATCH_INTERRUPT,
  output logic                    UPPER_MATCH_INTERRUPT,
  output logic                    TIMER_OUT,
  output logic                    CLOCK_ILLEGAL
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [`TCP_DIV_WIDTH-1:0]    hf_div;
    logic [`TCP_LF_DIV_WIDTH-1:0] lf_div;
    logic                         out_ff;
  } tcp_top_s;

  tcp_top_s st_r;
  tcp_top_s st_nxt;

  logic      slow_tap;
  logic      lower_tick;
  logic      upper_tick;
  logic      lower_ok;
  logic      upper_ok;
  logic      casc;
  logic      lower_run;
  logic      lower_wrap;
  logic      upper_match;
  logic      lower_match;
  logic      lower_cmp;
  logic      upper_cmp;
  logic      casc_match;
  logic      lower_run_eff;
  logic      upper_run_eff;
  tcp_mode_t eff_mode;
  tcp_ck_t   eff_ck;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Free-running dividers; one tick strobe per full wrap of each stage
  function automatic logic tap(input logic [`TCP_DIV_WIDTH-1:0] d,
                               input int n);
    logic [`TCP_DIV_WIDTH-1:0] mask;
    // Mask instead of a variable-width slice of the divider
    mask = `TCP_DIV_WIDTH'((1 << n) - 1);
    tap = HIGH_FREQ_CLOCK_EN && ((d & mask) == mask);
  endfunction

  // Legal source clock per mode and power state
  function automatic logic ck_legal(input tcp_mode_t m,
                                    input tcp_ck_t c);
    logic pwm;
    pwm = (m == `TCP_MODE_PWM8) || (m == `TCP_MODE_PWM16);
    ck_legal = 1'b0;
    if (m == `TCP_MODE_WARMUP) begin
      // R8: warm-up on raw high in slow state, raw low otherwise
      ck_legal = SLOW_STATE ? (c == `TCP_CK_HF) : (c == `TCP_CK_LF);
    end else if (SLOW_STATE) begin
      // R8: slowest tap only, or low clock for PWM
      ck_legal = (c == `TCP_CK_SLOWEST) || (pwm && c == `TCP_CK_LF);
    end else if (pwm) begin
      // R7: PWM any internal
      ck_legal = (c != `TCP_CK_PIN);
    end else begin
      // R7: four prescaled taps
      // Pin input belongs to the event counter, which is not built
      ck_legal = (c <= `TCP_CK_DIV3);
    end
  endfunction

  function automatic logic ck_tick(input tcp_ck_t c,
                                   input logic [`TCP_DIV_WIDTH-1:0] d);
    unique case (c)
      `TCP_CK_SLOWEST: ck_tick = slow_tap;
      `TCP_CK_DIV7:    ck_tick = tap(d, 7);
      `TCP_CK_DIV5:    ck_tick = tap(d, 5);
      `TCP_CK_DIV3:    ck_tick = tap(d, 3);
      `TCP_CK_LF:      ck_tick = LOW_FREQ_CLOCK_EN;
      `TCP_CK_DIV1:    ck_tick = tap(d, 1);
      `TCP_CK_HF:      ck_tick = HIGH_FREQ_CLOCK_EN;
      `TCP_CK_PIN:     ck_tick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Clock routing
  // ----------------------------------------------------------------
  always_comb begin
    // R18: slowest tap source
    slow_tap = (PRESCALER_TAP_SELECT || SLOW_STATE)
             ? (LOW_FREQ_CLOCK_EN && st_r.lf_div == '1)
             : tap(st_r.hf_div, `TCP_DIV_WIDTH);
    casc     = UPPER_MODE_SELECT[`TCP_MODE_CASC_BIT];
    // R5: cascade uses upper run
    lower_run = casc ? UPPER_RUN_CONTROL : LOWER_RUN_CONTROL;
    eff_mode  = casc ? UPPER_MODE_SELECT : LOWER_MODE_SELECT;
    eff_ck    = LOWER_CLOCK_SELECT;
    lower_ok  = ck_legal(eff_mode, eff_ck);
    upper_ok  = ck_legal(UPPER_MODE_SELECT, UPPER_CLOCK_SELECT);
    lower_tick = lower_ok && ck_tick(eff_ck, st_r.hf_div);
    // R3: upper clocked by overflow
    upper_tick = casc ? lower_wrap
               : (upper_ok && ck_tick(UPPER_CLOCK_SELECT, st_r.hf_div));
    // Byte compares only while not cascaded
    lower_cmp = !casc;
    upper_cmp = !casc;
    CLOCK_ILLEGAL = (lower_run && !lower_ok) ||
                    (!casc && UPPER_RUN_CONTROL && !upper_ok);
  end

  // ----------------------------------------------------------------
  // Cascade compare
  // ----------------------------------------------------------------
  // R14: both bytes compared on every lower tick
  // The upper byte only ticks at lower wrap, so its own compare
  // would only ever see a low byte of all ones
  always_comb begin
    casc_match = casc && UPPER_RUN_CONTROL && lower_tick &&
                 (UPPER_COUNT == UPPER_PERIOD) &&
                 (LOWER_COUNT == LOWER_PERIOD);
    // Dropping run for one edge clears both bytes on the match
    lower_run_eff = lower_run && !casc_match;
    upper_run_eff = UPPER_RUN_CONTROL && !casc_match;
  end

  tcp_counter8 u_lower (
    .clk    (CORE_CLK),
    .nrst   (NRST),
    .run    (lower_run_eff),
    .tick   (lower_tick),
    .cmp_en (lower_cmp),
    .period (LOWER_PERIOD),
    .count  (LOWER_COUNT),
    .match  (lower_match),
    .wrap   (lower_wrap)
  );

  // R17: period compared live
  tcp_counter8 u_upper (
    .clk    (CORE_CLK),
    .nrst   (NRST),
    .run    (upper_run_eff),
    .tick   (upper_tick),
    .cmp_en (upper_cmp),
    .period (UPPER_PERIOD),
    .count  (UPPER_COUNT),
    .match  (upper_match),
    .wrap   ()
  );

  // ----------------------------------------------------------------
  // Dividers and output flip-flop
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (HIGH_FREQ_CLOCK_EN) begin
      st_nxt.hf_div = st_r.hf_div + `TCP_DIV_WIDTH'(1);
    end
    if (LOW_FREQ_CLOCK_EN) begin
      st_nxt.lf_div = st_r.lf_div + `TCP_LF_DIV_WIDTH'(1);
    end
    // Initial level loaded while stopped; output toggles in divider mode
    if (!UPPER_RUN_CONTROL) begin
      st_nxt.out_ff = UPPER_FLIPFLOP_INIT;
    end else if (upper_match && UPPER_MODE_SELECT == `TCP_MODE_PDO8) begin
      st_nxt.out_ff = ~st_r.out_ff;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and pin
  // ----------------------------------------------------------------
  // R15: match clears and interrupts
  // R19: one-cycle pulse
  assign LOWER_MATCH_INTERRUPT = lower_match;
  assign UPPER_MATCH_INTERRUPT = upper_match || casc_match;
  // R6: suppress blocks output; pin is inverse of flip-flop
  assign TIMER_OUT = OUTPUT_SUPPRESS ? 1'b1 : ~st_r.out_ff;
endmodule

// ===== tcp_timer_pair_properties.sv
`timescale 1ns/100ps
module tcp_timer_pair_properties
  import tcp_pkg::*;
(
  input wire logic               CORE_CLK,
  input wire logic               NRST,
  input wire logic               SLOW_STATE,
  input wire tcp_pkg::tcp_mode_t LOWER_MODE_SELECT,
  input wire tcp_pkg::tcp_ck_t   LOWER_CLOCK_SELECT,
  input wire logic               LOWER_RUN_CONTROL,
  input wire tcp_pkg::tcp_byte_t LOWER_PERIOD,
  input wire tcp_pkg::tcp_mode_t UPPER_MODE_SELECT,
  input wire logic               UPPER_RUN_CONTROL,
  input wire tcp_pkg::tcp_byte_t UPPER_PERIOD,
  input wire logic               OUTPUT_SUPPRESS,
  input wire tcp_pkg::tcp_byte_t LOWER_COUNT,
  input wire tcp_pkg::tcp_byte_t UPPER_COUNT,
  input wire logic               LOWER_MATCH_INTERRUPT,
  input wire logic               UPPER_MATCH_INTERRUPT,
  input wire logic               TIMER_OUT,
  input wire logic               CLOCK_ILLEGAL
);
  // ------------------------------------
  // Sequences and properties
  // ------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  // Lower match outside cascade use
  sequence s_lmatch;
    LOWER_MATCH_INTERRUPT && !UPPER_MODE_SELECT[2];
  endsequence
  // Cascade held stopped, so both halves must read zero
  sequence s_cstop;
    (!UPPER_RUN_CONTROL && UPPER_MODE_SELECT[2])[*2];
  endsequence
  // Combined match in a 16-bit mode
  sequence s_cmatch;
    UPPER_MATCH_INTERRUPT && UPPER_MODE_SELECT[2];
  endsequence
  a_lmatch_value: assert property (s_lmatch |-> LOWER_COUNT == LOWER_PERIOD)
    else $error("lower match at wrong count");
  a_lmatch_clear: assert property (s_lmatch |=> LOWER_COUNT == 8'h00)
    else $error("lower count not cleared after match");
  a_lirq_pulse: assert property (LOWER_MATCH_INTERRUPT |=> !LOWER_MATCH_INTERRUPT)
    else $error("lower match longer than one cycle");
  a_uirq_pulse: assert property (UPPER_MATCH_INTERRUPT |=> !UPPER_MATCH_INTERRUPT)
    else $error("upper match longer than one cycle");
  a_count_step: assert property ($changed(LOWER_COUNT) |->
    LOWER_COUNT == $past(LOWER_COUNT) + 8'h01 || LOWER_COUNT == 8'h00)
    else $error("lower count jumped");
  a_casc_carry: assert property (UPPER_MODE_SELECT[2] && UPPER_RUN_CONTROL &&
    $changed(UPPER_COUNT) && UPPER_COUNT != 8'h00 |->
    LOWER_COUNT == 8'h00 && UPPER_COUNT == $past(UPPER_COUNT) + 8'h01)
    else $error("upper half moved without lower wrap");
  a_suppress_out: assert property (OUTPUT_SUPPRESS && $past(OUTPUT_SUPPRESS) |-> TIMER_OUT)
    else $error("timer output moved while suppressed");
  a_casc_stop: assert property (s_cstop |-> {UPPER_COUNT, LOWER_COUNT} == 16'h0000)
    else $error("stopped cascade not cleared");
  a_clock_illegal: assert property (LOWER_RUN_CONTROL && !UPPER_RUN_CONTROL &&
    !UPPER_MODE_SELECT[2] && LOWER_MODE_SELECT == 3'h0 && !SLOW_STATE &&
    LOWER_CLOCK_SELECT[2] |-> CLOCK_ILLEGAL)
    else $error("fast raw clock accepted in timer mode");
  a_casc_value: assert property (s_cmatch |->
    {UPPER_COUNT, LOWER_COUNT} == {UPPER_PERIOD, LOWER_PERIOD})
    else $error("cascade match at wrong count");
  a_casc_clear: assert property (s_cmatch |=>
    {UPPER_COUNT, LOWER_COUNT} == 16'h0000)
    else $error("cascade count not cleared after match");
endmodule

bind tcp_timer_pair tcp_timer_pair_properties u_props (.*);

// ===== tb.sv
`timescale 1ns/100ps
module tb;
  import tcp_pkg::*;
  logic        CORE_CLK, NRST, HIGH_FREQ_CLOCK_EN, LOW_FREQ_CLOCK_EN;
  logic        SLOW_STATE, PRESCALER_TAP_SELECT, LOWER_RUN_CONTROL;
  logic        UPPER_RUN_CONTROL, UPPER_FLIPFLOP_INIT, OUTPUT_SUPPRESS;
  logic        LOWER_MATCH_INTERRUPT, UPPER_MATCH_INTERRUPT, TIMER_OUT;
  logic        CLOCK_ILLEGAL;
  tcp_mode_t   LOWER_MODE_SELECT, UPPER_MODE_SELECT;
  tcp_ck_t     LOWER_CLOCK_SELECT, UPPER_CLOCK_SELECT;
  tcp_byte_t   LOWER_PERIOD, UPPER_PERIOD, LOWER_COUNT, UPPER_COUNT, p;
  logic [15:0] expq[$];
  logic [31:0] seed = 32'h4714;
  int          err_total = 0;
  int          checked = 0;

  tcp_timer_pair DUT (.*);

  // Free-running core clock
  initial begin
    CORE_CLK = 1'h0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  // ------------------------------------
  // Helpers
  // ------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait until every noted match has been seen
  task automatic drain(input int lim);
    for (int i = 0; i < lim && expq.size() != 0; i++) @(posedge CORE_CLK);
    if (expq.size() != 0) begin
      err_total++;
      $display("[ERR] %0t match never came", $time);
      finish_test();
    end
  endtask
  // fields only change while stopped, never on the stopping edge
  task automatic cfg(input tcp_mode_t lm, um, input tcp_ck_t lc, uc,
                     input tcp_byte_t lp, up);
    @(posedge CORE_CLK);
    LOWER_MODE_SELECT <= lm;
    UPPER_MODE_SELECT <= um;
    LOWER_CLOCK_SELECT <= lc;
    UPPER_CLOCK_SELECT <= uc;
    LOWER_PERIOD <= lp;
    UPPER_PERIOD <= up;
  endtask
  task automatic go(input logic l, u);
    @(posedge CORE_CLK);
    LOWER_RUN_CONTROL <= l;
    UPPER_RUN_CONTROL <= u;
    repeat (3) @(posedge CORE_CLK);
  endtask
  // Each cycle with a match pulse takes the oldest noted count pair
  always @(posedge CORE_CLK) begin
    if (NRST === 1'h1 && (LOWER_MATCH_INTERRUPT | UPPER_MATCH_INTERRUPT)) begin
      if (expq.size() == 0) begin
        err_total++;
        $display("[ERR] %0t unexpected match", $time);
      end else
        cmp({UPPER_COUNT, LOWER_COUNT}, expq.pop_front());
    end
  end
  // ------------------------------------
  // Main sequence
  // ------------------------------------
  initial begin
    {NRST, HIGH_FREQ_CLOCK_EN, LOW_FREQ_CLOCK_EN, SLOW_STATE} = 4'h4;
    {PRESCALER_TAP_SELECT, LOWER_RUN_CONTROL, UPPER_RUN_CONTROL} = 3'h0;
    // flip-flop level held zero through the timer-mode tests
    // PWM and PROGRAMMABLE_PULSE are not run, so no width value is set
    {UPPER_FLIPFLOP_INIT, OUTPUT_SUPPRESS} = 2'h0;
    {LOWER_MODE_SELECT, UPPER_MODE_SELECT} = 6'h00;
    {LOWER_CLOCK_SELECT, UPPER_CLOCK_SELECT} = 6'h00;
    {LOWER_PERIOD, UPPER_PERIOD} = 16'h0101;
    repeat (20) @(posedge CORE_CLK);
    NRST <= 1'h1;
    // matches on the DIV7, DIV5 and DIV3 taps, period 1 to 4
    for (int k = 1; k < 4; k++) begin
      p = 8'(rnd() % 4 + 1);
      cfg(3'h0, 3'h0, 3'(k), 3'h0, p, 8'h01);
      repeat (2) expq.push_back({8'h00, p});
      go(1'h1, 1'h0);
      drain(2500);
      go(1'h0, 1'h0);
    end
    $display("test timer8 done");
    cfg(3'h0, 3'h0, 3'h6, 3'h0, 8'h02, 8'h01);
    go(1'h1, 1'h0);
    repeat (40) @(posedge CORE_CLK);
    cmp({15'h0, CLOCK_ILLEGAL}, 16'h0001);
    cmp({8'h00, LOWER_COUNT}, 16'h0000);
    go(1'h0, 1'h0);
    // slowest tap from low clock, by tap select then slow state
    for (int k = 1; k < 3; k++) begin
      {SLOW_STATE, PRESCALER_TAP_SELECT} <= 2'(k);
      {HIGH_FREQ_CLOCK_EN, LOW_FREQ_CLOCK_EN} <= 2'h1;
      cfg(3'h0, 3'h0, 3'h3, 3'h0, 8'h02, 8'h01);
      go(1'h1, 1'h0);
      cmp({15'h0, CLOCK_ILLEGAL}, 16'(k - 1));
      go(1'h0, 1'h0);
      cfg(3'h0, 3'h0, 3'h0, 3'h0, 8'h02, 8'h01);
      expq.push_back(16'h0002);
      go(1'h1, 1'h0);
      cmp({15'h0, CLOCK_ILLEGAL}, 16'h0000);
      drain(300);
      go(1'h0, 1'h0);
    end
    $display("test clocks done");
    // timer16 on a fast tap, then warm-up on the low
    // clock; lower mode 011, upper clock ignored, period 256 at least
    {HIGH_FREQ_CLOCK_EN, LOW_FREQ_CLOCK_EN, SLOW_STATE} <= 3'h6;
    PRESCALER_TAP_SELECT <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      p = (k == 0) ? 8'(rnd()) : 8'h00;
      cfg(3'h3, 3'(4 + k), (k == 0) ? 3'h3 : 3'h4, 3'h6, p, 8'h01);
      expq.push_back({8'h01, p});
      go(1'h0, 1'h1);
      drain(5000);
      go(1'h0, 1'h0);
    end
    $display("test cascade done");
    // divider output held idle while suppressed
    OUTPUT_SUPPRESS <= 1'h1;
    cfg(3'h0, 3'h1, 3'h0, 3'h3, 8'h01, 8'h03);
    expq.push_back(16'h0300);
    go(1'h0, 1'h1);
    drain(200);
    cmp({15'h0, TIMER_OUT}, 16'h0001);
    OUTPUT_SUPPRESS <= 1'h0;
    repeat (3) @(posedge CORE_CLK);
    cmp({15'h0, TIMER_OUT}, 16'h0000);
    go(1'h0, 1'h0);
    // stopped output takes the upper flip-flop level, pin inverted
    UPPER_FLIPFLOP_INIT <= 1'h1;
    repeat (2) @(posedge CORE_CLK);
    cmp({15'h0, TIMER_OUT}, 16'h0000);
    $display("test suppress done");
    finish_test();
  end
endmodule
